/* File: core/asq_pkg.sv */
// Constants, register map and state type for the sampling sequencer
package asq_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL1 = 8'h00;
	localparam logic [7:0] OFF_CTRL3 = 8'h04;
	localparam logic [7:0] OFF_CHSEL = 8'h08;
	localparam logic [7:0] OFF_START = 8'h0c;
	localparam logic [7:0] OFF_RES_A = 8'h10;
	localparam logic [7:0] OFF_RES_B = 8'h14;
	localparam logic [7:0] OFF_STAT  = 8'h18;
	localparam logic [7:0] OFF_ICLR  = 8'h1c;
	localparam logic [7:0] OFF_IEN   = 8'h20;
	// Field positions
	localparam int ACQ_LSB   = 8;
	localparam int ACQ_W     = 4;
	localparam int MODE_BIT  = 4;
	localparam int CONT_BIT  = 5;
	localparam int BGR_LSB   = 6;
	localparam int PWR_BIT   = 5;
	localparam int CLKEN_BIT = 0;
	localparam int START_BIT = 0;
	localparam int CHSEL_W   = 4;
	localparam int STS_W     = 3;
	localparam int BUSY_BIT  = 8;
	localparam int OPER_BIT  = 9;
	localparam int RES_W     = 12;
	// Writable bits and reset values
	localparam logic [31:0] CTRL1_MASK = 32'h0000_0f30;
	localparam logic [31:0] CTRL3_MASK = 32'h0000_00e1;
	localparam logic [31:0] CHSEL_MASK = 32'h0000_000f;
	localparam logic [31:0] IEN_MASK   = 32'h0000_0007;
	localparam logic [31:0] CTRL1_RST  = 32'h0000_0000;
	localparam logic [31:0] CTRL3_RST  = 32'h0000_0000;
	localparam logic [31:0] CHSEL_RST  = 32'h0000_0000;
	localparam logic [31:0] IEN_RST    = 32'h0000_0000;
	// Timing: system clock rate and converter clock period
	localparam int CLK_MHZ      = 250;
	localparam int CONV_NS      = 40;
	localparam int HALF_DIV_DEF = CONV_NS * CLK_MHZ / 1000 / 2;
	// Timing in converter half periods; flag delay in system clocks
	localparam int TRIG_HALVES  = 5;
	localparam int LAT_A_HALVES = 8;
	localparam int LAT_B_HALVES = 10;
	localparam int GAP_SEQ_HALVES = 2;
	localparam int GAP_SIM_HALVES = 4;
	localparam int FLAG_DLY     = 2;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_DELAY = 4'b0010,
		ST_HOLD  = 4'b0100,
		ST_GAP   = 4'b1000
	} asq_state_t;
endpackage : asq_pkg

/* File: core/asq_sequencer.sv */
// Sampling and conversion sequencer for a 16-input pipelined converter
// Notes on behaviour
// - Mode bit 0 converts one selected channel per sample/hold pulse.
// - A pwm_module event, software write or external start pin starts it.
// - Interrupt flags rise a few system clocks after the result write.
// - Sequential mode captures the channel at the sample/hold falling edge.
// - Sample/hold pulse spans 1 to 16 converter clocks.
// - Sampling starts 2.5 converter clocks after the trigger.
// - Acquisition lasts 1 plus the 4-bit count in control bits 8 to 11.
// - Sequential result after 4 clocks, then every 2 plus count clocks.
// - Simultaneous: A after 4, B after 5, pairs every 3 plus count.
// - Mode bit 1 converts one channel pair per sample/hold pulse.
// - Both pair channels are sampled on the same falling edge.
// - Sixteen inputs, software chooses one channel or a pair.
// - Twelve-bit results through an overlapping ten-stage pipeline.
// - Operational only with bandgap, reference, power and converter clock enabled.
module asq_sequencer
	import asq_pkg::*;
#(
	parameter int HALF_DIV = HALF_DIV_DEF,
	parameter int LAT_A    = LAT_A_HALVES,
	parameter int LAT_B    = LAT_B_HALVES
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst,
	// Register port
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	// Start triggers
	input  wire logic              pwm_trig,
	input  wire logic              external_start_pin,
	// Held values from the analog front end
	input  wire logic [RES_W-1:0]  conv_a_data,
	input  wire logic [RES_W-1:0]  conv_b_data,
	// Front end control
	output logic                   sh_pulse,
	output logic [2:0]             mux_sel,
	output logic                   grp_b_sel,
	// Interrupt
	output logic                   irq
);
	localparam int TRIG_CYC = TRIG_HALVES * HALF_DIV + 1;
	localparam int LATA_LO  = LAT_A * HALF_DIV - 1;
	localparam int LATA_HI  = LATA_LO + HALF_DIV;
	localparam int PAIR_LO  = (LAT_B - LAT_A) * HALF_DIV;
	localparam int PAIR_HI  = PAIR_LO + HALF_DIV - 1;
	localparam int GAPS_CYC = GAP_SEQ_HALVES * HALF_DIV;
	localparam int FLAG_CYC = FLAG_DLY + 1;

	asq_state_t           st_q, st_d;
	logic [5:0]           cnt_q, cnt_d;
	logic                 sh_q, sh_d, samp;
	logic [7:0]           div_q;
	logic [31:0]          ctrl1_q, ctrl3_q, chsel_q, ien_q, rdata_q;
	logic [STS_W-1:0]     sts_q;
	logic [RES_W-1:0]     res_a_q, res_b_q;
	logic [LAT_B-1:0]     pv_q, pm_q;
	logic [RES_W-1:0]     pa_q [LAT_B];
	logic [RES_W-1:0]     pb_q [LAT_B];
	logic [FLAG_DLY-1:0]  fa_q, fb_q;
	logic                 irq_q;
	logic                 grp_q;
	logic [15:0]          sh_len_q;

	// Register decode
	wire wr_ctrl1 = reg_wr && (reg_addr == OFF_CTRL1);
	wire wr_ctrl3 = reg_wr && (reg_addr == OFF_CTRL3);
	wire wr_chsel = reg_wr && (reg_addr == OFF_CHSEL);
	wire wr_start = reg_wr && (reg_addr == OFF_START);
	wire wr_iclr  = reg_wr && (reg_addr == OFF_ICLR);
	wire wr_ien   = reg_wr && (reg_addr == OFF_IEN);

	// Control fields
	wire [ACQ_W-1:0] acq  = ctrl1_q[ACQ_LSB +: ACQ_W];
	wire             mode = ctrl1_q[MODE_BIT];
	wire             cont = ctrl1_q[CONT_BIT];
	wire             bgr_on = &ctrl3_q[BGR_LSB +: 2];
	wire             op = bgr_on && ctrl3_q[PWR_BIT]
		&& ctrl3_q[CLKEN_BIT];

	// Triggers: any source starts an idle, powered converter
	wire sw_trig  = wr_start && reg_wdata[START_BIT];
	wire trig_any = pwm_trig || external_start_pin || sw_trig;
	wire acc      = trig_any && op && (st_q == ST_IDLE);
	wire ign      = trig_any && !op;

	// Half-period tick; restarted at a trigger so the delay is exact
	wire ht = (div_q == 8'(HALF_DIV - 1));
	wire [5:0] hold_ld = {1'b0, acq, 1'b1};
	wire [5:0] gap_ld  = mode ? 6'(GAP_SIM_HALVES - 1)
		: 6'(GAP_SEQ_HALVES - 1);

	// Pipeline taps; a result in flight is dropped once power is lost
	wire wr_a = ht && pv_q[LAT_A-1] && op;
	wire wr_b = ht && pv_q[LAT_B-1] && pm_q[LAT_B-1] && op;

	// Status and read data
	wire [STS_W-1:0] sts_set = {ign, fb_q[FLAG_DLY-1], fa_q[FLAG_DLY-1]};
	wire [STS_W-1:0] sts_clr = wr_iclr ? reg_wdata[STS_W-1:0] : '0;
	wire [31:0] stat_val = {22'h0, op, st_q != ST_IDLE, 5'h0, sts_q};
	wire [31:0] rd_val =
		(reg_addr == OFF_CTRL1) ? ctrl1_q :
		(reg_addr == OFF_CTRL3) ? ctrl3_q :
		(reg_addr == OFF_CHSEL) ? chsel_q :
		(reg_addr == OFF_RES_A) ? {20'h0, res_a_q} :
		(reg_addr == OFF_RES_B) ? {20'h0, res_b_q} :
		(reg_addr == OFF_STAT)  ? stat_val :
		(reg_addr == OFF_IEN)   ? ien_q : 32'h0;

	// Sequencer: delay, hold window, gap between continuous samples
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		sh_d  = sh_q;
		samp  = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (acc) begin
					st_d  = ST_DELAY;
					cnt_d = 6'(TRIG_HALVES - 1);
				end
			end
			ST_DELAY: begin
				if (ht && cnt_q == 6'h0) begin
					st_d  = ST_HOLD;
					cnt_d = hold_ld;
					sh_d  = 1'b1;
				end else if (ht) begin
					cnt_d = cnt_q - 6'h1;
				end
			end
			ST_HOLD: begin
				if (ht && cnt_q == 6'h0) begin
					samp  = 1'b1;
					sh_d  = 1'b0;
					st_d  = cont ? ST_GAP : ST_IDLE;
					cnt_d = gap_ld;
				end else if (ht) begin
					cnt_d = cnt_q - 6'h1;
				end
			end
			ST_GAP: begin
				if (ht && cnt_q == 6'h0) begin
					st_d  = ST_HOLD;
					cnt_d = hold_ld;
					sh_d  = 1'b1;
				end else if (ht) begin
					cnt_d = cnt_q - 6'h1;
				end
			end
			default: st_d = ST_IDLE;
		endcase
		// Losing power or clock aborts the sequence
		if (!op) begin
			st_d = ST_IDLE;
			sh_d = 1'b0;
			samp = 1'b0;
		end
	end

	// Sequencer state and divider
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q  <= ST_IDLE;
			cnt_q <= 6'h0;
			sh_q  <= 1'b0;
			div_q <= 8'h0;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
			sh_q  <= sh_d;
			div_q <= (acc || ht) ? 8'h0 : div_q + 8'h1;
		end
	end

	// Conversion pipeline; several samples overlap in flight
	always_ff @(posedge mclk) begin
		if (rst || !op) begin
			pv_q <= '0;
			pm_q <= '0;
		end else if (ht) begin
			pv_q <= {pv_q[LAT_B-2:0], samp};
			pm_q <= {pm_q[LAT_B-2:0], mode};
		end
	end

	// Pipeline data carries no reset, validity travels in pv_q
	always_ff @(posedge mclk) begin
		if (ht) begin
			pa_q[0] <= conv_a_data;
			pb_q[0] <= conv_b_data;
			for (int i = 1; i < LAT_B; i++) begin
				pa_q[i] <= pa_q[i-1];
				pb_q[i] <= pb_q[i-1];
			end
		end
	end

	// Result registers, then flags delayed behind them
	always_ff @(posedge mclk) begin
		if (rst) begin
			res_a_q <= '0;
			res_b_q <= '0;
			fa_q    <= '0;
			fb_q    <= '0;
		end else begin
			if (wr_a)
				res_a_q <= pa_q[LAT_A-1];
			if (wr_b)
				res_b_q <= pb_q[LAT_B-1];
			fa_q <= {fa_q[FLAG_DLY-2:0], wr_a};
			fb_q <= {fb_q[FLAG_DLY-2:0], wr_b};
		end
	end

	// Software registers; a set in the clear cycle wins
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl1_q <= CTRL1_RST;
			ctrl3_q <= CTRL3_RST;
			chsel_q <= CHSEL_RST;
			ien_q   <= IEN_RST;
			sts_q   <= '0;
			irq_q   <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			if (wr_ctrl1)
				ctrl1_q <= reg_wdata & CTRL1_MASK;
			if (wr_ctrl3)
				ctrl3_q <= reg_wdata & CTRL3_MASK;
			if (wr_chsel)
				chsel_q <= reg_wdata & CHSEL_MASK;
			if (wr_ien)
				ien_q <= reg_wdata & IEN_MASK;
			sts_q   <= (sts_q & ~sts_clr) | sts_set;
			irq_q   <= |(sts_q & ien_q[STS_W-1:0]);
			rdata_q <= reg_rd ? rd_val : 32'h0;
		end
	end

	// Channel select; a pair always shares its index in both groups
	assign mux_sel   = chsel_q[2:0];
	assign grp_b_sel = grp_q;
	assign sh_pulse  = sh_q;
	assign irq       = irq_q;
	assign reg_rdata = rdata_q;

	// Group B select is registered so the pin comes straight from a flop
	always_ff @(posedge mclk) begin
		if (rst)
			grp_q <= 1'b0;
		else
			grp_q <= chsel_q[3] && !mode;
	end

	// Helper: length of the current hold window in system clocks
	always_ff @(posedge mclk) begin
		if (rst || !sh_q)
			sh_len_q <= 16'h0;
		else
			sh_len_q <= sh_len_q + 16'h1;
	end

	trig_ignore_a: assert property (@(posedge mclk) disable iff (rst)
		ign |=> st_q == ST_IDLE && sts_q[2])
		else $error("trigger acted while unpowered");
	no_result_a: assert property (@(posedge mclk) disable iff (rst)
		!op |-> (!wr_a && !wr_b) ##1 (!sh_q && pv_q == '0))
		else $error("activity while not operational");
	trig_delay_a: assert property (@(posedge mclk) disable iff (rst)
		acc |-> ##TRIG_CYC ($rose(sh_q) || !op))
		else $error("trigger to sampling delay wrong");
	sh_width_a: assert property (@(posedge mclk) disable iff (rst)
		$fell(sh_q) && op |-> sh_len_q == 2 * (acq + 1) * HALF_DIV)
		else $error("hold window width wrong");
	lat_a_a: assert property (@(posedge mclk) disable iff (rst)
		$fell(sh_q) && op |-> ##[LATA_LO:LATA_HI] (wr_a || !op))
		else $error("first result latency wrong");
	pair_b_a: assert property (@(posedge mclk) disable iff (rst)
		wr_a && pm_q[LAT_A-1] |-> ##[PAIR_LO:PAIR_HI] (wr_b || !op))
		else $error("group B result late");
	flag_after_a: assert property (@(posedge mclk) disable iff (rst)
		wr_a && !wr_iclr |-> !sts_set[0] ##FLAG_CYC sts_q[0])
		else $error("flag not set after result");
	cont_gap_a: assert property (@(posedge mclk) disable iff (rst)
		$fell(sh_q) && cont && !mode && op
		|-> ##GAPS_CYC ($rose(sh_q) || !op))
		else $error("continuous sample spacing wrong");
	seq_run_c: cover property (@(posedge mclk) disable iff (rst)
		wr_a && !pm_q[LAT_A-1]);
	sim_run_c: cover property (@(posedge mclk) disable iff (rst) wr_b);
	cont_run_c: cover property (@(posedge mclk) disable iff (rst)
		$rose(sh_q) && st_q == ST_GAP);
	ignored_c: cover property (@(posedge mclk) disable iff (rst) ign);
	busy_trig_c: cover property (@(posedge mclk) disable iff (rst)
		trig_any && op && st_q != ST_IDLE);
endmodule : asq_sequencer

/* File: tb/asq_front_model.sv */
// Behavioural analog front end that answers the sequencer's channel select
module asq_front_model
	import asq_pkg::*;
(
	// Sequencer control
	input  wire logic             sh_pulse,
	input  wire logic [2:0]       mux_sel,
	input  wire logic             grp_b_sel,
	// Held values
	output logic      [RES_W-1:0] conv_a_data,
	output logic      [RES_W-1:0] conv_b_data
);
	logic [RES_W-1:0] code_a;
	logic [RES_W-1:0] code_b;
	// Each code names its channel, so a wrong mux choice shows in the result
	assign code_a = {grp_b_sel, mux_sel, 8'h3c};
	assign code_b = {1'b1, mux_sel, grp_b_sel ? 8'h3c : 8'hc3};
	// Outside the hold window the value is inverted, so late sampling shows
	assign conv_a_data = sh_pulse ? code_a : ~code_a;
	assign conv_b_data = sh_pulse ? code_b : ~code_b;
endmodule : asq_front_model

/* File: tb/tb.sv */
// Self-checking bench for the sampling sequencer
module tb
	import asq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int H = 2;
	logic             mclk = 1'b0;
	logic             rst = 1'b1;
	logic             reg_wr = 1'b0;
	logic             reg_rd = 1'b0;
	logic             pwm_trig = 1'b0;
	logic             external_start_pin = 1'b0;
	logic [7:0]       reg_addr = 8'h00;
	logic [31:0]      reg_wdata = 32'h0;
	logic [31:0]      reg_rdata;
	logic [31:0]      rv;
	logic [RES_W-1:0] conv_a_data;
	logic [RES_W-1:0] conv_b_data;
	logic             sh_pulse;
	logic             grp_b_sel;
	logic             irq;
	logic [2:0]       mux_sel;
	int               fails = 0;
	int               n_checks = 0;
	// Small divider keeps the run short
	asq_sequencer #(.HALF_DIV(H)) u_asq_sequencer (
		.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pwm_trig(pwm_trig), .external_start_pin(external_start_pin),
		.conv_a_data(conv_a_data), .conv_b_data(conv_b_data),
		.sh_pulse(sh_pulse), .mux_sel(mux_sel), .grp_b_sel(grp_b_sel),
		.irq(irq));
	asq_front_model u_asq_front_model (
		.sh_pulse(sh_pulse), .mux_sel(mux_sel), .grp_b_sel(grp_b_sel),
		.conv_a_data(conv_a_data), .conv_b_data(conv_b_data));
	// Clock
	always #2 mclk = ~mclk;
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask : rd
	// Edges until sh_pulse (or irq) reaches lvl; 400 means it never did
	task automatic cnt(input bit use_irq, input logic lvl, output int n);
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (((use_irq ? irq : sh_pulse) !== lvl) && n < 400);
	endtask : cnt
	// Trigger source: 0 pwm, 1 software, 2 external pin
	task automatic fire(input int k);
		if (k == 1) begin
			wr(OFF_START, 32'h1);
		end else begin
			@(posedge mclk);
			if (k == 0) pwm_trig <= 1'b1;
			else external_start_pin <= 1'b1;
			@(posedge mclk);
			pwm_trig <= 1'b0;
			external_start_pin <= 1'b0;
		end
	endtask : fire
	task automatic reset_run();
		rd(OFF_CTRL1);
		chk(rv, CTRL1_RST);
		chk({26'h0, sh_pulse, irq, grp_b_sel, mux_sel}, 32'h0);
		wr(8'h40, 32'hffff_ffff);
		rd(8'h40);
		chk(rv, 32'h0);
		$display("test reset done");
	endtask : reset_run
	// Power bit off: trigger must be refused and flagged
	task automatic off_run();
		int n;
		wr(OFF_IEN, 32'h4);
		wr(OFF_CTRL3, 32'hc1);
		fire(0);
		cnt(0, 1'b1, n);
		chk(32'(n), 32'd400);
		rd(OFF_STAT);
		chk(rv, 32'h4);
		chk({31'h0, irq}, 32'h1);
		wr(OFF_ICLR, 32'h4);
		rd(OFF_RES_A);
		chk(rv, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// Powered but with the converter clock gated: still refused
		wr(OFF_CTRL3, 32'he0);
		fire(2);
		rd(OFF_STAT);
		chk(rv, 32'h4);
		wr(OFF_ICLR, 32'h4);
		$display("test powered-down trigger done");
	endtask : off_run
	task automatic conv(input int k, input logic mode, input logic [3:0] acq,
		input logic [3:0] ch);
		int n;
		logic [RES_W-1:0] ea;
		ea = {ch[3] & ~mode, ch[2:0], 8'h3c};
		wr(OFF_ICLR, 32'h7);
		wr(OFF_CTRL1, {20'h0, acq, 2'b00, 1'b0, mode, 4'h0});
		wr(OFF_CHSEL, {28'h0, ch});
		fire(k);
		cnt(0, 1'b1, n);
		chk(32'(n), 32'(5 * H));
		cnt(0, 1'b0, n);
		chk(32'(n), 32'(2 * (acq + 1) * H));
		cnt(1, 1'b1, n);
		chk(32'(n), 32'(8 * H + 3));
		// Leave room for the group B result and its flag
		repeat (4 * H) @(posedge mclk);
		rd(OFF_RES_A);
		chk(rv, {20'h0, ea});
		if (mode) begin
			rd(OFF_RES_B);
			chk(rv, {20'h0, 1'b1, ch[2:0], 8'hc3});
		end
		rd(OFF_STAT);
		chk(rv, {22'h0, 2'b10, 6'h0, mode, 1'b1});
		$display("test conversion mode %0d trigger %0d done", mode, k);
	endtask : conv
	// Continuous run: pulse period is (2 + acq) or (3 + acq) clocks
	task automatic cont_run(input logic mode);
		int n;
		wr(OFF_CTRL1, {20'h0, 4'h2, 2'b00, 1'b1, mode, 4'h0});
		fire(2);
		cnt(0, 1'b1, n);
		repeat (2) begin
			cnt(0, 1'b0, n);
			cnt(0, 1'b1, n);
			chk(32'(n), 32'((mode ? 4 : 2) * H));
		end
		// A trigger while busy is dropped without a flag
		fire(0);
		wr(OFF_CTRL1, {20'h0, 4'h2, 2'b00, 1'b0, mode, 4'h0});
		repeat (80) @(posedge mclk);
		rd(OFF_STAT);
		chk({30'h0, rv[BUSY_BIT], rv[2]}, 32'h0);
		$display("test continuous mode %0d done", mode);
	endtask : cont_run
	// Main sequence
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		reset_run();
		off_run();
		wr(OFF_CTRL3, 32'he1);
		wr(OFF_IEN, 32'h7);
		conv(0, 1'b0, 4'h3, 4'hb);
		conv(1, 1'b1, 4'h0, 4'h5);
		conv(2, 1'b0, 4'hf, 4'h2);
		cont_run(1'b0);
		cont_run(1'b1);
		final_report();
	end
	// Watchdog: the sequence needs a few thousand cycles at most
	initial begin
		#50us;
		fails++;
		$display("Error at %0t: watchdog expired", $time);
		final_report();
	end
endmodule : tb
